// ### src/memory_map_decoder.sv
// Memory map decoder: places registers, RAM, EEPROM, ROM and boot ROM
`timescale 1ns/10ps
module memory_map_decoder (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// Mode pins, captured once after reset
	input  wire logic        i_mode_select_low,
	input  wire logic        i_mode_select_high,
	// Nonvolatile configuration bits
	input  wire logic        i_rom_present_bit,
	input  wire logic        i_rom_position_bit,
	input  wire logic        i_eeprom_enable,
	// CPU bus access
	input  wire logic        i_valid,
	input  wire logic        i_write,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	// Region selects, one cycle after the access
	output logic             o_sel_reg,
	output logic             o_sel_ram,
	output logic             o_sel_eeprom,
	output logic             o_sel_boot,
	output logic             o_sel_rom,
	output logic             o_sel_ext,
	output logic [14:0]      o_offset,
	// Read-back of the mapping registers
	output logic             o_rd_valid,
	output logic [7:0]       o_rd_data,
	// Current map state
	output logic             o_mode_valid,
	output logic [1:0]       o_mode,
	output logic [3:0]       o_ram_page,
	output logic [3:0]       o_register_page,
	output logic [3:0]       o_eeprom_page,
	output logic             o_rom_present,
	output logic             o_rom_position
);

	////////////////////////////////////////////////////////////////////////////////
	// Types and state

	typedef struct packed {
		logic [mm_pkg::NUM_RG-1:0] sel;
		logic [14:0]               offset;
		logic                      rd_valid;
		logic [7:0]                rd_data;
		logic                      mode_valid;
		logic [1:0]                mode;
		logic [3:0]                ram_page;
		logic [3:0]                reg_page;
		logic [3:0]                ee_page;
		logic                      rom_present;
		logic                      rom_position;
	} dec_t;

	dec_t state_reg;
	dec_t state_next;

	map_cfg_if cfg ();

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Address lies in the given 4k page
	function automatic logic page_hit(input logic [15:0] addr, input logic [3:0] page);
		page_hit = (addr[15:12] == page);
	endfunction

	// Page offset within [lo, hi)
	function automatic logic ofs_in(input logic [15:0] addr, input logic [11:0] lo,
		input logic [11:0] hi);
		ofs_in = (addr[11:0] >= lo) && (addr[11:0] < hi);
	endfunction

	// Register block hit at one register offset
	function automatic logic reg_at(input logic [15:0] addr, input logic [3:0] page,
		input logic [11:0] ofs);
		reg_at = page_hit(addr, page) && (addr[11:0] == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Mode strap and map registers

	mode_strap u_strap (
		.i_ref_clk          (i_ref_clk),
		.i_rst_n            (i_rst_n),
		.i_mode_select_low  (i_mode_select_low),
		.i_mode_select_high (i_mode_select_high),
		.cfg                (cfg.strap)
	);

	logic wr_hit_map;
	logic wr_hit_ee;

	// Map register writes go through the current register page
	assign wr_hit_map = i_valid && i_write
		&& reg_at(i_addr, cfg.reg_page, mm_pkg::MAP_REG_OFS);
	assign wr_hit_ee = i_valid && i_write
		&& reg_at(i_addr, cfg.reg_page, mm_pkg::EE_POS_OFS);

	map_regs u_regs (
		.i_ref_clk    (i_ref_clk),
		.i_rst_n      (i_rst_n),
		.i_wr_hit_map (wr_hit_map),
		.i_wr_hit_ee  (wr_hit_ee),
		.i_wdata      (i_wdata),
		.cfg          (cfg.regs)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Effective configuration per mode

	logic rom_present_eff;
	logic rom_position_eff;
	logic boot_on;
	logic ext_on;
	logic same_page;

	always_comb begin
		rom_present_eff  = i_rom_present_bit;
		rom_position_eff = i_rom_position_bit;
		boot_on          = 1'b0;
		ext_on           = 1'b0;
		case (cfg.mode)
			mm_pkg::MODE_SINGLE: begin
				rom_position_eff = 1'b1;
			end
			mm_pkg::MODE_EXP: begin
				ext_on = 1'b1;
			end
			mm_pkg::MODE_BOOT: begin
				rom_position_eff = 1'b1;
				boot_on          = 1'b1;
			end
			mm_pkg::MODE_TEST: begin
				rom_present_eff = 1'b0;
				ext_on          = 1'b1;
			end
			default: begin
				ext_on = 1'b0;
			end
		endcase
	end

	// RAM and registers sharing a page shifts RAM up past the register block
	assign same_page = (cfg.ram_page == cfg.reg_page);

	////////////////////////////////////////////////////////////////////////////////
	// Raw region hits

	logic [mm_pkg::NUM_RG-1:0] hit;
	logic                      ram_sec1;
	logic                      boot_vec;

	// Placement uses the effective bits; single chip and bootstrap force the ROM high
	always_comb begin
		hit      = '0;
		ram_sec1 = same_page && ofs_in(i_addr, mm_pkg::RAM_SEC1_BASE, mm_pkg::RAM_SEC1_END);
		boot_vec = boot_on && (i_addr[15:6] == mm_pkg::BOOT_VEC);
		hit[mm_pkg::RG_REG] = page_hit(i_addr, cfg.reg_page)
			&& ofs_in(i_addr, 12'h000, mm_pkg::REG_BLK_END);
		if (same_page) begin
			hit[mm_pkg::RG_RAM] = page_hit(i_addr, cfg.ram_page) && (ram_sec1
				|| ofs_in(i_addr, mm_pkg::RAM_SEC2_BASE, mm_pkg::RAM_PLAIN_END));
		end else begin
			hit[mm_pkg::RG_RAM] = page_hit(i_addr, cfg.ram_page)
				&& ofs_in(i_addr, 12'h000, mm_pkg::RAM_PLAIN_END);
		end
		hit[mm_pkg::RG_EE] = i_eeprom_enable && page_hit(i_addr, cfg.ee_page)
			&& (i_addr[11:0] >= mm_pkg::EE_BASE);
		hit[mm_pkg::RG_BOOT] = boot_vec
			|| (boot_on && (i_addr[15:9] == mm_pkg::BOOT_BLK));
		hit[mm_pkg::RG_ROM] = rom_present_eff
			&& (i_addr[15] == rom_position_eff);
		hit[mm_pkg::RG_EXT] = ext_on;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Priority: each region wins only if no higher one claimed the address

	logic [mm_pkg::NUM_RG:0]   taken;
	logic [mm_pkg::NUM_RG-1:0] win;

	assign taken[0] = 1'b0;

	// External bus gets only what every on-chip region left
	genvar g;
	generate
		for (g = 0; g < mm_pkg::NUM_RG; g++) begin : g_prio
			assign win[g]       = hit[g] && !taken[g];
			assign taken[g + 1] = taken[g] || hit[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Offset inside the winning region

	logic [14:0] ofs;

	always_comb begin
		ofs = '0;
		if (win[mm_pkg::RG_REG]) begin
			ofs = {8'h00, i_addr[6:0]};
		end else if (win[mm_pkg::RG_RAM]) begin
			if (ram_sec1) begin
				ofs = {8'h00, i_addr[6:0]};
			end else begin
				ofs = {5'h00, i_addr[9:0]};
			end
		end else if (win[mm_pkg::RG_EE]) begin
			ofs = {3'h0, i_addr[11:0] - mm_pkg::EE_BASE};
		end else if (win[mm_pkg::RG_BOOT]) begin
			// Vector fetches land on the top of the boot block
			if (boot_vec) begin
				ofs = {6'h00, mm_pkg::BOOT_VEC_HI, i_addr[5:0]};
			end else begin
				ofs = {6'h00, i_addr[8:0]};
			end
		end else if (win[mm_pkg::RG_ROM]) begin
			ofs = i_addr[14:0];
		end else if (win[mm_pkg::RG_EXT]) begin
			ofs = i_addr[14:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	logic rd_map;
	logic rd_ee;

	assign rd_map = reg_at(i_addr, cfg.reg_page, mm_pkg::MAP_REG_OFS);
	assign rd_ee  = reg_at(i_addr, cfg.reg_page, mm_pkg::EE_POS_OFS);

	always_comb begin
		state_next              = state_reg;
		state_next.sel          = '0;
		state_next.offset       = '0;
		state_next.rd_valid     = 1'b0;
		state_next.rd_data      = '0;
		state_next.mode_valid   = cfg.mode_valid;
		state_next.mode         = cfg.mode;
		state_next.ram_page     = cfg.ram_page;
		state_next.reg_page     = cfg.reg_page;
		state_next.ee_page      = cfg.ee_page;
		state_next.rom_present  = rom_present_eff;
		state_next.rom_position = rom_position_eff;
		// Accesses before the mode is known select nothing
		if (i_valid && cfg.mode_valid) begin
			state_next.sel    = win;
			state_next.offset = ofs;
			if (!i_write && (rd_map || rd_ee)) begin
				state_next.rd_valid = 1'b1;
				if (rd_map) begin
					state_next.rd_data = {cfg.ram_page, cfg.reg_page};
				end else begin
					// Low bits of that register belong to other blocks
					state_next.rd_data = {cfg.ee_page, 4'h0};
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_sel_reg       = state_reg.sel[mm_pkg::RG_REG];
	assign o_sel_ram       = state_reg.sel[mm_pkg::RG_RAM];
	assign o_sel_eeprom    = state_reg.sel[mm_pkg::RG_EE];
	assign o_sel_boot      = state_reg.sel[mm_pkg::RG_BOOT];
	assign o_sel_rom       = state_reg.sel[mm_pkg::RG_ROM];
	assign o_sel_ext       = state_reg.sel[mm_pkg::RG_EXT];
	assign o_offset        = state_reg.offset;
	assign o_rd_valid      = state_reg.rd_valid;
	assign o_rd_data       = state_reg.rd_data;
	assign o_mode_valid    = state_reg.mode_valid;
	assign o_mode          = state_reg.mode;
	assign o_ram_page      = state_reg.ram_page;
	assign o_register_page = state_reg.reg_page;
	assign o_eeprom_page   = state_reg.ee_page;
	assign o_rom_present   = state_reg.rom_present;
	assign o_rom_position  = state_reg.rom_position;

endmodule

// ### src/mm_pkg.sv
// Constants, types and field layouts shared by the memory map decoder files
package mm_pkg;

	// Operating mode, as coded by {mode_select_high, mode_select_low}
	typedef enum logic [1:0] {
		MODE_BOOT   = 2'b00,
		MODE_TEST   = 2'b01,
		MODE_SINGLE = 2'b10,
		MODE_EXP    = 2'b11
	} op_mode_t;

	// Strap register value before the first capture
	localparam op_mode_t MODE_RST = MODE_SINGLE;

	// Page nibbles after reset
	localparam logic [3:0] RAM_PAGE_RST = 4'h0;
	localparam logic [3:0] REG_PAGE_RST = 4'h0;
	localparam logic [3:0] EE_PAGE_RST  = 4'h0;

	// Register block: offsets 000..07F of its page
	localparam logic [11:0] REG_BLK_END = 12'h080;
	localparam logic [11:0] MAP_REG_OFS = 12'h03D;
	localparam logic [11:0] EE_POS_OFS  = 12'h037;

	// Field positions inside the mapping and EEPROM position registers
	localparam int RAM_NIB_LSB = 4;
	localparam int REG_NIB_LSB = 0;
	localparam int EE_NIB_LSB  = 4;

	// RAM placement within its page
	localparam logic [11:0] RAM_PLAIN_END = 12'h400;
	localparam logic [11:0] RAM_SEC2_BASE = 12'h080;
	localparam logic [11:0] RAM_SEC1_BASE = 12'h400;
	localparam logic [11:0] RAM_SEC1_END  = 12'h480;

	// EEPROM window xD80..xFFF
	localparam logic [11:0] EE_BASE = 12'hD80;

	// Bootloader ROM: claims the whole 512-byte block BE00..BFFF
	localparam logic [6:0] BOOT_BLK   = 7'h5F;
	// Vector area FFC0..FFFF served from the top of the boot block
	localparam logic [9:0] BOOT_VEC   = 10'h3FF;
	localparam logic [2:0] BOOT_VEC_HI = 3'h7;

	// Region indices, highest priority first
	localparam int RG_REG  = 0;
	localparam int RG_RAM  = 1;
	localparam int RG_EE   = 2;
	localparam int RG_BOOT = 3;
	localparam int RG_ROM  = 4;
	localparam int RG_EXT  = 5;
	localparam int NUM_RG  = 6;

endpackage

// ### src/map_cfg_if.sv
// Mapping configuration carried between strap capture, map registers and decoder
`timescale 1ns/10ps
interface map_cfg_if;
	mm_pkg::op_mode_t mode;
	logic             mode_valid;
	logic [3:0]       ram_page;
	logic [3:0]       reg_page;
	logic [3:0]       ee_page;

	modport strap (output mode, output mode_valid);
	modport regs  (input mode_valid, output ram_page, output reg_page, output ee_page);
	modport dec   (input mode, input mode_valid, input ram_page, input reg_page,
		input ee_page);
endinterface

// ### src/mode_strap.sv
// Captures the two mode-select pins once, on the first edge after reset release
`timescale 1ns/10ps
module mode_strap (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	// Mode pins
	input  wire logic i_mode_select_low,
	input  wire logic i_mode_select_high,
	// Captured mode
	map_cfg_if.strap  cfg
);
	typedef struct packed {
		mm_pkg::op_mode_t mode;
		logic             valid;
	} strap_t;

	strap_t state_reg;
	strap_t state_next;

	// Pins are sampled once; later pin changes must not move the map
	always_comb begin
		state_next = state_reg;
		if (!state_reg.valid) begin
			state_next.mode  = mm_pkg::op_mode_t'({i_mode_select_high, i_mode_select_low});
			state_next.valid = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= '{mode: mm_pkg::MODE_RST, valid: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign cfg.mode       = state_reg.mode;
	assign cfg.mode_valid = state_reg.valid;
endmodule

// ### src/map_regs.sv
// Mapping register and EEPROM position register, written by the CPU
`timescale 1ns/10ps
module map_regs (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// CPU write
	input  wire logic        i_wr_hit_map,
	input  wire logic        i_wr_hit_ee,
	input  wire logic [7:0]  i_wdata,
	// Page nibbles
	map_cfg_if.regs          cfg
);
	typedef struct packed {
		logic [3:0] ram_page;
		logic [3:0] reg_page;
		logic [3:0] ee_page;
	} pages_t;

	pages_t state_reg;
	pages_t state_next;

	always_comb begin
		state_next = state_reg;
		if (cfg.mode_valid && i_wr_hit_map) begin
			state_next.ram_page = i_wdata[mm_pkg::RAM_NIB_LSB +: 4];
			state_next.reg_page = i_wdata[mm_pkg::REG_NIB_LSB +: 4];
		end
		if (cfg.mode_valid && i_wr_hit_ee) begin
			state_next.ee_page = i_wdata[mm_pkg::EE_NIB_LSB +: 4];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= '{ram_page: mm_pkg::RAM_PAGE_RST,
				reg_page: mm_pkg::REG_PAGE_RST,
				ee_page: mm_pkg::EE_PAGE_RST};
		end else begin
			state_reg <= state_next;
		end
	end

	assign cfg.ram_page = state_reg.ram_page;
	assign cfg.reg_page = state_reg.reg_page;
	assign cfg.ee_page  = state_reg.ee_page;
endmodule

// ### bench/memory_map_decoder_props.sv
// Concurrent checks on the memory map decoder ports
`timescale 1ns/10ps
module mm_props (
	// Clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	// Configuration and access
	input wire logic        i_rom_present_bit,
	input wire logic        i_eeprom_enable,
	input wire logic        i_valid,
	input wire logic        i_write,
	input wire logic [15:0] i_addr,
	// Region selects
	input wire logic        o_sel_reg,
	input wire logic        o_sel_ram,
	input wire logic        o_sel_eeprom,
	input wire logic        o_sel_boot,
	input wire logic        o_sel_rom,
	input wire logic        o_sel_ext,
	input wire logic [14:0] o_offset,
	// Read-back and map state
	input wire logic        o_rd_valid,
	input wire logic [7:0]  o_rd_data,
	input wire logic        o_mode_valid,
	input wire logic [1:0]  o_mode,
	input wire logic [3:0]  o_ram_page,
	input wire logic [3:0]  o_register_page,
	input wire logic        o_rom_present,
	input wire logic        o_rom_position
);
	wire logic [5:0] sel = {o_sel_reg, o_sel_ram, o_sel_eeprom, o_sel_boot, o_sel_rom, o_sel_ext};

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	AST_ONE_REGION: assert property ($onehot0(sel))
		else $error("more than one region selected");
	AST_SEL_CAUSE: assert property (|sel |-> $past(i_valid))
		else $error("select without an access");
	AST_BOOT_MODE_ONLY: assert property (o_sel_boot |-> o_mode == mm_pkg::MODE_BOOT)
		else $error("boot rom selected outside bootstrap");
	AST_TEST_NO_ROM: assert property ((o_mode_valid && o_mode == mm_pkg::MODE_TEST)
		|-> !o_rom_present && !o_sel_rom)
		else $error("rom present in test mode");
	AST_SINGLE_HIGH_ROM: assert property ((o_mode_valid && o_mode == mm_pkg::MODE_SINGLE)
		|-> o_rom_position)
		else $error("rom not high in single chip");
	AST_EXT_MODES: assert property (o_sel_ext |-> o_mode_valid && o_mode[0])
		else $error("external cycle in a closed mode");
	AST_EE_ENABLED: assert property (o_sel_eeprom |-> $past(i_eeprom_enable))
		else $error("eeprom selected while disabled");
	AST_ROM_PRESENT: assert property (o_sel_rom |-> $past(i_rom_present_bit))
		else $error("rom selected while absent");
	AST_REG_PAGE: assert property ((i_valid && o_mode_valid && !$past(i_valid && i_write)
		&& i_addr[15:12] == o_register_page && i_addr[11:7] == 5'h00)
		|=> o_sel_reg && o_offset == {8'h00, $past(i_addr[6:0])})
		else $error("register block access missed");
	AST_MAP_READ: assert property ((i_valid && !i_write && o_mode_valid
		&& !$past(i_valid && i_write) && i_addr == {o_register_page, 12'h03D})
		|=> o_rd_valid && o_rd_data == {$past(o_ram_page), $past(o_register_page)})
		else $error("mapping register read wrong");
endmodule

bind memory_map_decoder mm_props i_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_rom_present_bit(i_rom_present_bit), .i_eeprom_enable(i_eeprom_enable),
	.i_valid(i_valid), .i_write(i_write), .i_addr(i_addr), .o_sel_reg(o_sel_reg),
	.o_sel_ram(o_sel_ram), .o_sel_eeprom(o_sel_eeprom), .o_sel_boot(o_sel_boot),
	.o_sel_rom(o_sel_rom), .o_sel_ext(o_sel_ext), .o_offset(o_offset),
	.o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_mode_valid(o_mode_valid),
	.o_mode(o_mode), .o_ram_page(o_ram_page), .o_register_page(o_register_page),
	.o_rom_present(o_rom_present), .o_rom_position(o_rom_position));

// ### bench/cpu_bus_model.sv
// Behavioural CPU core issuing single byte accesses
`timescale 1ns/10ps
module cpu_bus_model (
	// Clock
	input  wire logic        i_ref_clk,
	// Bus access
	output logic             o_valid,
	output logic             o_write,
	output logic [15:0]      o_addr,
	output logic [7:0]       o_wdata
);
	initial begin
		o_valid = 1'b0;
		o_write = 1'b0;
		o_addr  = 16'h0000;
		o_wdata = 8'h00;
	end

	// Idle lines carry the inverse so a stale address cannot match
	task automatic access(input logic [15:0] addr, input logic wr, input logic [7:0] data);
		@(posedge i_ref_clk);
		o_valid <= 1'b1;
		o_write <= wr;
		o_addr  <= addr;
		o_wdata <= data;
		@(posedge i_ref_clk);
		o_valid <= 1'b0;
		o_write <= ~wr;
		o_addr  <= ~addr;
		o_wdata <= ~data;
	endtask
endmodule

// ### bench/memory_map_decoder_test.sv
// Directed tests of the memory map decoder through the CPU bus model
`timescale 1ns/10ps
module memory_map_decoder_test;
	localparam logic [5:0] S_REG  = 6'h20;
	localparam logic [5:0] S_RAM  = 6'h10;
	localparam logic [5:0] S_EE   = 6'h08;
	localparam logic [5:0] S_BOOT = 6'h04;
	localparam logic [5:0] S_ROM  = 6'h02;
	localparam logic [5:0] S_EXT  = 6'h01;
	localparam logic [5:0] S_NONE = 6'h00;

	logic        ref_clk, rst_n, mode_low, mode_high, cfg_rom_pres, cfg_rom_pos, ee_enable;
	logic        valid, write, rd_valid, mode_valid, eff_rom_present, eff_rom_position;
	logic        sel_reg, sel_ram, sel_eeprom, sel_boot, sel_rom, sel_ext;
	logic [15:0] addr;
	logic [7:0]  wdata, rd_data;
	logic [14:0] offset;
	logic [1:0]  mode;
	logic [3:0]  ram_page, register_page, eeprom_page;
	int          fails, compares;
	wire  [5:0]  sel = {sel_reg, sel_ram, sel_eeprom, sel_boot, sel_rom, sel_ext};

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	cpu_bus_model i_cpu (.i_ref_clk(ref_clk), .o_valid(valid), .o_write(write),
		.o_addr(addr), .o_wdata(wdata));

	memory_map_decoder i_dut (
		.i_ref_clk(ref_clk), .i_rst_n(rst_n),
		.i_mode_select_low(mode_low), .i_mode_select_high(mode_high),
		.i_rom_present_bit(cfg_rom_pres), .i_rom_position_bit(cfg_rom_pos),
		.i_eeprom_enable(ee_enable), .i_valid(valid), .i_write(write),
		.i_addr(addr), .i_wdata(wdata),
		.o_sel_reg(sel_reg), .o_sel_ram(sel_ram), .o_sel_eeprom(sel_eeprom),
		.o_sel_boot(sel_boot), .o_sel_rom(sel_rom), .o_sel_ext(sel_ext),
		.o_offset(offset), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
		.o_mode_valid(mode_valid), .o_mode(mode), .o_ram_page(ram_page),
		.o_register_page(register_page), .o_eeprom_page(eeprom_page),
		.o_rom_present(eff_rom_present), .o_rom_position(eff_rom_position));

	////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Selects and offset stand for one cycle only, so they are read right after the edge
	task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d,
		input logic [5:0] s, input logic [14:0] o);
		i_cpu.access(a, w, d);
		#1;
		cmp({10'h000, sel}, {10'h000, s});
		cmp({1'b0, offset}, {1'b0, o});
	endtask

	task automatic rd(input logic [15:0] a, input logic [5:0] s, input logic [14:0] o);
		acc(a, 1'b0, 8'h00, s, o);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc(a, 1'b1, d, S_REG, {8'h00, a[6:0]});
	endtask

	task automatic start(input logic [1:0] m, input logic rp, input logic rpos, input logic ee);
		int n;
		@(posedge ref_clk);
		rst_n        <= 1'b0;
		mode_high    <= m[1];
		mode_low     <= m[0];
		cfg_rom_pres <= rp;
		cfg_rom_pos  <= rpos;
		ee_enable    <= ee;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		n = 0;
		while (mode_valid !== 1'b1 && n < 10) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n == 10) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, mode_valid, 1'b1);
			finish_test();
		end
		cmp({14'h0000, mode}, {14'h0000, m});
		cmp({8'h00, ram_page, register_page}, 16'h0000);
	endtask

	task automatic end_test(input string name);
		$display("test %s done, mismatches so far %0d", name, fails);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		{mode_high, mode_low, cfg_rom_pres, cfg_rom_pos, ee_enable} = 5'h00;
		fails = 0;
		compares = 0;
		start(mm_pkg::MODE_SINGLE, 1'b1, 1'b0, 1'b1);
		cmp({15'h0000, eff_rom_position}, 16'h0001);
		rd(16'h0000, S_REG, 15'h0000);
		rd(16'h007F, S_REG, 15'h007F);
		rd(16'h0080, S_RAM, 15'h0080);
		rd(16'h0400, S_RAM, 15'h0000);
		rd(16'h047F, S_RAM, 15'h007F);
		rd(16'h0D80, S_EE, 15'h0000);
		rd(16'h0FFF, S_EE, 15'h027F);
		rd(16'h8000, S_ROM, 15'h0000);
		rd(16'hFFFF, S_ROM, 15'h7FFF);
		rd(16'h5000, S_NONE, 15'h0000);
		rd(16'hBE40, S_ROM, 15'h3E40);
		rd(16'h003D, S_REG, 15'h003D);
		cmp({7'h00, rd_valid, rd_data}, 16'h0100);
		wr(16'h003D, 8'h1F);
		cmp({7'h00, rd_valid, rd_data}, 16'h0000);
		rd(16'hF000, S_REG, 15'h0000);
		cmp({8'h00, ram_page, register_page}, 16'h001F);
		rd(16'h0000, S_NONE, 15'h0000);
		rd(16'h1000, S_RAM, 15'h0000);
		rd(16'h13FF, S_RAM, 15'h03FF);
		rd(16'hF03D, S_REG, 15'h003D);
		cmp({7'h00, rd_valid, rd_data}, 16'h011F);
		wr(16'hF037, 8'h5A);
		rd(16'h5D80, S_EE, 15'h0000);
		cmp({12'h000, eeprom_page}, 16'h0005);
		rd(16'hF037, S_REG, 15'h0037);
		cmp({7'h00, rd_valid, rd_data}, 16'h0150);
		wr(16'hF03D, 8'h8F);
		rd(16'h8000, S_RAM, 15'h0000);
		rd(16'h8400, S_ROM, 15'h0400);
		wr(16'hF037, 8'h90);
		rd(16'h9D80, S_EE, 15'h0000);
		end_test("single chip");
		start(mm_pkg::MODE_EXP, 1'b1, 1'b0, 1'b0);
		rd(16'h0000, S_REG, 15'h0000);
		rd(16'h0080, S_RAM, 15'h0080);
		rd(16'h0D80, S_ROM, 15'h0D80);
		rd(16'h7FFF, S_ROM, 15'h7FFF);
		rd(16'h8000, S_EXT, 15'h0000);
		end_test("expanded");
		start(mm_pkg::MODE_TEST, 1'b1, 1'b1, 1'b1);
		cmp({15'h0000, eff_rom_present}, 16'h0000);
		rd(16'h8000, S_EXT, 15'h0000);
		rd(16'h0D80, S_EE, 15'h0000);
		end_test("special test");
		start(mm_pkg::MODE_BOOT, 1'b1, 1'b0, 1'b1);
		rd(16'hBE40, S_BOOT, 15'h0040);
		rd(16'hBE00, S_BOOT, 15'h0000);
		rd(16'hBFFF, S_BOOT, 15'h01FF);
		rd(16'hFFFE, S_BOOT, 15'h01FE);
		rd(16'h9000, S_ROM, 15'h1000);
		rd(16'h5000, S_NONE, 15'h0000);
		end_test("bootstrap");
		start(mm_pkg::MODE_SINGLE, 1'b0, 1'b1, 1'b1);
		rd(16'h8000, S_NONE, 15'h0000);
		end_test("rom absent");
		finish_test();
	end
endmodule
